// ===== rmd_regs.svh
`ifndef RMD_REGS_SVH
`define RMD_REGS_SVH

// Register word indices; byte address is four times the index.
`define RMD_SEL_IDX    8'h6F
`define RMD_STAT_IDX   8'h70

// Mirror selection register layout and reset value.
`define RMD_SEL_EN_BIT 0
`define RMD_SEL_RST    8'h01

// Address map of the 24-bit space.
`define RMD_LOCAL_BANK 8'h00
`define RMD_ROM_BANK   8'hFF
`define RMD_MIR_LO     16'h4000

`endif

// ===== rmd_pkg.sv
`default_nettype none
package rmd_pkg;

	typedef enum logic [1:0] {
		RMD_TGT_LOCAL = 2'b00,
		RMD_TGT_ROM   = 2'b01,
		RMD_TGT_EXT   = 2'b10
	} rmd_tgt_t;

	typedef enum logic [0:0] {
		RMD_BUS_IDLE = 1'b0,
		RMD_BUS_ACK  = 1'b1
	} rmd_bus_t;

	typedef struct packed {
		rmd_tgt_t    tgt;
		logic        mirrored;
		logic [23:0] addr;
	} rmd_dec_t;

endpackage
`default_nettype wire

// ===== rmd_decoder.sv
`include "rmd_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rmd_decoder (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                rom_in_use,
	input  wire logic                cpu_req,
	input  wire logic                cpu_wr,
	input  wire logic [23:0]         cpu_addr,
	output var  logic                mem_req,
	output var  logic                mem_wr,
	output var  rmd_pkg::rmd_dec_t   mem_dec,
	input  wire logic [7:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output var  logic [31:0]         avs_readdata,
	output logic                     avs_waitrequest
);
	import rmd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State.

	logic              mem_req_r;
	logic              mem_req_nxt;
	logic              mem_wr_r;
	logic              mem_wr_nxt;
	rmd_dec_t          dec_r;
	rmd_dec_t          dec_nxt;
	logic [7:0]        sel_r;
	logic [7:0]        sel_nxt;
	rmd_bus_t          bus_r;
	rmd_bus_t          bus_nxt;
	logic [31:0]       rdata_r;
	logic [31:0]       rdata_nxt;
	logic              mirror_on;
	logic              in_mirror;

	assign mirror_on = rom_in_use & sel_r[`RMD_SEL_EN_BIT];
	assign in_mirror = (cpu_addr[23:16] == `RMD_LOCAL_BANK) &&
	                   (cpu_addr[15:0] >= `RMD_MIR_LO);

	////////////////////////////////////////////////////////////////////////////
	// Address decode, one registered result per CPU request.

	always_comb begin
		mem_req_nxt = cpu_req;
		mem_wr_nxt  = cpu_req & cpu_wr;
		dec_nxt     = dec_r;
		if (cpu_req) begin
			dec_nxt.addr     = cpu_addr;
			dec_nxt.mirrored = 1'b0;
			if (cpu_addr[23:16] == `RMD_ROM_BANK) begin
				dec_nxt.tgt = RMD_TGT_ROM;
			end else if (cpu_addr[23:16] == `RMD_LOCAL_BANK) begin
				if (in_mirror && mirror_on && !cpu_wr) begin
					dec_nxt.tgt        = RMD_TGT_ROM;
					dec_nxt.mirrored   = 1'b1;
					dec_nxt.addr       = {`RMD_ROM_BANK, cpu_addr[15:0]};
				end else begin
					dec_nxt.tgt = RMD_TGT_LOCAL;
				end
			end else begin
				dec_nxt.tgt = RMD_TGT_EXT;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mem_req_r <= 1'b0;
			mem_wr_r  <= 1'b0;
			dec_r     <= '{tgt: RMD_TGT_LOCAL, mirrored: 1'b0, addr: 24'h000000};
		end else begin
			mem_req_r <= mem_req_nxt;
			mem_wr_r  <= mem_wr_nxt;
			dec_r     <= dec_nxt;
		end
	end

	assign mem_req = mem_req_r;
	assign mem_wr  = mem_wr_r;
	assign mem_dec = dec_r;

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: request taken in idle, answered one cycle later.

	always_comb begin
		bus_nxt   = bus_r;
		sel_nxt   = sel_r;
		rdata_nxt = rdata_r;
		case (bus_r)
			RMD_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_nxt   = RMD_BUS_ACK;
					rdata_nxt = 32'h00000000;
					if (avs_read && avs_address == `RMD_STAT_IDX) begin
						rdata_nxt = {27'h0000000, dec_r.mirrored, dec_r.tgt,
						             sel_r[`RMD_SEL_EN_BIT], mirror_on};
					end
				end
			end
			RMD_BUS_ACK: begin
				bus_nxt = RMD_BUS_IDLE;
				if (avs_write && avs_byteenable[0] &&
				    avs_address == `RMD_SEL_IDX) begin
					sel_nxt = avs_writedata[7:0];
				end
			end
			default: begin
				bus_nxt = RMD_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus_r   <= RMD_BUS_IDLE;
			sel_r   <= `RMD_SEL_RST;
			rdata_r <= 32'h00000000;
		end else begin
			bus_r   <= bus_nxt;
			sel_r   <= sel_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// The selection register is not read back at its own index, which reads zero; status bit 1 shows its enable bit.
	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = (avs_read | avs_write) & (bus_r != RMD_BUS_ACK);

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	req_follow_a: assert property (
		cpu_req |=> mem_req && (mem_dec.addr[15:0] == $past(cpu_addr[15:0])))
		else $error("decoded request missing or low address changed");

	ext_span_a: assert property (
		cpu_req && cpu_addr[23:16] != 8'h00 && cpu_addr[23:16] != 8'hFF
		|=> mem_dec.tgt == RMD_TGT_EXT && mem_dec.addr == $past(cpu_addr))
		else $error("outer bank not sent to external space");

	mirror_rom_a: assert property (
		cpu_req && !cpu_wr && in_mirror && rom_in_use && sel_r[0]
		|=> mem_dec.tgt == RMD_TGT_ROM && mem_dec.mirrored)
		else $error("mirrored read not sent to ROM");

	bank_swap_a: assert property (
		mem_req && mem_dec.mirrored
		|-> mem_dec.addr[23:16] == 8'hFF && $past(cpu_addr[23:16]) == 8'h00)
		else $error("mirror bank substitution wrong");

	example_c000_a: assert property (
		cpu_req && !cpu_wr && cpu_addr == 24'h00C000 && mirror_on
		|=> mem_dec.addr == 24'hFFC000 && mem_dec.tgt == RMD_TGT_ROM)
		else $error("00C000 not mapped to FFC000");

	low_window_a: assert property (
		cpu_req && cpu_addr[23:16] == 8'h00 && cpu_addr[15:0] < 16'h4000
		|=> mem_dec.tgt == RMD_TGT_LOCAL && !mem_dec.mirrored)
		else $error("address below 004000 mirrored");

	sel_reset_a: assert property (
		$rose(resetn) |-> sel_r[0] && avs_readdata == 32'h00000000)
		else $error("selection bit 0 not one after reset");

	sel_hidden_a: assert property (
		bus_r == RMD_BUS_IDLE && avs_read && avs_address == 8'h6F
		|=> avs_readdata == 32'h00000000 && !avs_waitrequest)
		else $error("write-only register read back");

	mirror_off_a: assert property (
		cpu_req && cpu_addr[23:16] == 8'h00 && !sel_r[0]
		|=> mem_dec.tgt == RMD_TGT_LOCAL)
		else $error("mirroring active while disabled");

	rom_off_a: assert property (
		cpu_req && cpu_addr[23:16] == 8'h00 && !rom_in_use
		|=> mem_dec.tgt == RMD_TGT_LOCAL && !mem_dec.mirrored)
		else $error("mirroring active without internal ROM");

	write_local_a: assert property (
		cpu_req && cpu_wr && cpu_addr[23:16] == 8'h00
		|=> mem_dec.tgt == RMD_TGT_LOCAL && !mem_dec.mirrored && mem_wr)
		else $error("write in bank 00 sent to ROM");

	rom_bank_a: assert property (
		cpu_req && cpu_addr[23:16] == 8'hFF
		|=> mem_dec.tgt == RMD_TGT_ROM && !mem_dec.mirrored &&
		    mem_dec.addr == $past(cpu_addr))
		else $error("bank FF not decoded to ROM");

	req_pulse_a: assert property (
		!cpu_req |=> !mem_req)
		else $error("decoded request without CPU request");

	sel_write_a: assert property (
		bus_r == RMD_BUS_ACK && avs_write && avs_byteenable[0] &&
		avs_address == `RMD_SEL_IDX
		|=> sel_r == $past(avs_writedata[7:0]))
		else $error("selection register write lost");

	sel_keep_a: assert property (
		!(bus_r == RMD_BUS_ACK && avs_write && avs_byteenable[0] &&
		  avs_address == `RMD_SEL_IDX)
		|=> sel_r == $past(sel_r))
		else $error("selection register changed without write");

	status_read_a: assert property (
		bus_r == RMD_BUS_IDLE && avs_read && avs_address == `RMD_STAT_IDX
		|=> avs_readdata[1:0] == {$past(sel_r[0]), $past(mirror_on)})
		else $error("status read does not show selection");

	answer_next_a: assert property (
		bus_r == RMD_BUS_IDLE && (avs_read || avs_write)
		|=> bus_r == RMD_BUS_ACK)
		else $error("register request not answered next cycle");

endmodule
`default_nettype wire

// ===== rmd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module rmd_cpu_model (
	input  wire logic        clk,
	output var  logic        cpu_req,
	output var  logic [23:0] cpu_addr,
	output var  logic        cpu_wr
);
	initial begin
		cpu_req = 1'b0;
		cpu_wr = 1'b0;
		cpu_addr = 24'h000000;
	end
	// Issues one access; ROM tables sit at FF4000 to FFFFFF.
	task acc(input logic w, input logic [23:0] a);
		@(posedge clk);
		cpu_req <= 1'b1;
		cpu_wr <= w;
		cpu_addr <= a;
		@(posedge clk);
		cpu_req <= 1'b0;
		cpu_wr <= ~w;
		cpu_addr <= ~a;
	endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmd_regs.svh"
module testbench;
	import rmd_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        rom_in_use = 1'b1;
	logic        cpu_req, cpu_wr, mem_req, mem_wr, avs_waitrequest;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [23:0] cpu_addr;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [3:0]  be_req = 4'hF;
	logic [31:0] avs_readdata, q;
	rmd_dec_t    mem_dec;
	int          miscompares = 0;
	int          tests_run = 0;
	always #5 clk = ~clk;
	rmd_cpu_model cpu_u (.clk(clk), .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr));
	rmd_decoder dut_u (.clk(clk), .resetn(resetn), .rom_in_use(rom_in_use),
		.cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .mem_req(mem_req),
		.mem_wr(mem_wr), .mem_dec(mem_dec), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task av(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		avs_byteenable <= be_req;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			$display("Error avs_waitrequest expected 0 seen 1");
			miscompares++;
		end
	endtask
	task dec(input logic w, input logic [23:0] a, input logic [26:0] e);
		int n;
		n = 0;
		cpu_u.acc(w, a);
		while (mem_req !== 1'b1 && n < 5) begin
			@(negedge clk);
			n++;
		end
		chk("mem_req", 32'h1, {31'h0, mem_req});
		chk("mem_dec", {5'h0, e}, {5'h0, mem_dec});
		chk("mem_wr", {31'h0, w}, {31'h0, mem_wr});
		@(negedge clk);
		chk("mem_req_drop", 32'h0, {31'h0, mem_req});
	endtask
	task conclude();
		$display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		$display("Error watchdog expected finish seen timeout");
		miscompares++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		av(1'b0, `RMD_STAT_IDX, 32'h0);
		chk("status", 32'h03, q);
		av(1'b0, `RMD_SEL_IDX, 32'h0);
		chk("sel_read", 32'h0, q);
		av(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("Test registers done.");
		dec(1'b0, 24'h00C000, {RMD_TGT_ROM, 1'b1, 24'hFFC000});
		dec(1'b0, 24'h004000, {RMD_TGT_ROM, 1'b1, 24'hFF4000});
		dec(1'b0, 24'h00FFFF, {RMD_TGT_ROM, 1'b1, 24'hFFFFFF});
		dec(1'b0, 24'h003FFF, {RMD_TGT_LOCAL, 1'b0, 24'h003FFF});
		dec(1'b1, 24'h00C000, {RMD_TGT_LOCAL, 1'b0, 24'h00C000});
		dec(1'b0, 24'hFF1234, {RMD_TGT_ROM, 1'b0, 24'hFF1234});
		dec(1'b0, 24'h123456, {RMD_TGT_EXT, 1'b0, 24'h123456});
		dec(1'b0, 24'h80ABCD, {RMD_TGT_EXT, 1'b0, 24'h80ABCD});
		$display("Test mirror decode done.");
		@(posedge clk);
		rom_in_use <= 1'b0;
		dec(1'b0, 24'h00C000, {RMD_TGT_LOCAL, 1'b0, 24'h00C000});
		@(posedge clk);
		rom_in_use <= 1'b1;
		av(1'b1, `RMD_SEL_IDX, 32'hFFFFFF00);
		dec(1'b0, 24'h00C000, {RMD_TGT_LOCAL, 1'b0, 24'h00C000});
		av(1'b0, `RMD_STAT_IDX, 32'h0);
		chk("status", 32'h00, q);
		av(1'b1, `RMD_SEL_IDX, 32'h01);
		dec(1'b0, 24'h00E000, {RMD_TGT_ROM, 1'b1, 24'hFFE000});
		be_req = 4'hE;
		av(1'b1, `RMD_SEL_IDX, 32'h00);
		be_req = 4'hF;
		av(1'b0, `RMD_STAT_IDX, 32'h0);
		chk("status_lanes", 32'h17, q);
		$display("Test selection done.");
		av(1'b1, `RMD_SEL_IDX, 32'h00);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		av(1'b0, `RMD_STAT_IDX, 32'h0);
		chk("status_rst", 32'h03, q);
		chk("mem_dec_rst", 32'h0, {5'h0, mem_dec});
		dec(1'b0, 24'h00C000, {RMD_TGT_ROM, 1'b1, 24'hFFC000});
		$display("Test reset done.");
		conclude();
	end
endmodule
`default_nettype wire
